/* File: wdt_pkg.sv */
// Purpose: Shared constants and types of the watchdog/interval timer.
// Assumes: AXI4-Lite slave with 32-bit data; byte address = 4 * index.
// Notes: Printed offsets are indices, not byte addresses.
package wdt_pkg;
  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;
  localparam logic [IDX_W-1:0] IDX_CLOCK_SELECT = 16'hff42;
  localparam logic [IDX_W-1:0] IDX_MODE_CONTROL = 16'hfff9;
  localparam logic [IDX_W-1:0] IDX_IRQ_FLAG_REG0 = 16'h0010;

  // Clock select field
  localparam int CSEL_LSB = 0;
  localparam int CSEL_W = 3;
  localparam logic [2:0] CSEL_RESET = 3'h0;

  // Mode control fields
  localparam int RUN_BIT = 7;
  localparam int WD_SEL_BIT = 4;
  localparam int OVF_ACT_BIT = 3;

  // Interrupt flag register fields
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_MASK_BIT = 1;
  localparam logic IRQ_MASK_RESET = 1'b1;

  // Prescaler and counter
  localparam int PRESC_W = 10;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] CNT_MAX = 7'h7f;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic run;
    logic wd_sel;
    logic ovf_act;
    logic [2:0] clk_sel;
  } wdt_ctrl_t;

  localparam wdt_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, CSEL_RESET};
endpackage

/* File: wdt_prescaler.sv */
// Purpose: Free-running divider giving one-cycle count ticks.
// Assumes: Select codes 000, 010, 100, 110; bit 0 of the code is ignored.
// Notes: Never cleared by a restart, so the first period may be short.
module wdt_prescaler #(
  parameter int W = wdt_pkg::PRESC_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [W-1:0] div;
  logic [W-1:0] next_div;
  logic [W-1:0] tap_mask;

  always_comb begin
    unique case (sel[2:1])
      2'h0: tap_mask = W'(16'h000f);
      2'h1: tap_mask = W'(16'h003f);
      2'h2: tap_mask = W'(16'h00ff);
      2'h3: tap_mask = W'(16'h03ff);
    endcase
  end

  // Divide by 16, 64, 256 or 1024
  assign tick = enable && ((div & tap_mask) == tap_mask);

  always_comb begin
    next_div = div;
    if (enable) begin
      next_div = W'(div + 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div <= '0;
    end else begin
      div <= next_div;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_tick_spacing: assert property (tick |=> !tick)
    else $error("prescaler tick lasted two cycles");
  chk_tick_frozen: assert property (!enable |-> !tick ##1 $stable(div))
    else $error("prescaler moved while frozen");
endmodule

/* File: wdt_timer.sv */
// Purpose: Watchdog / interval timer with an AXI4-Lite register slave.
// Assumes: cpu_halt and cpu_stop come from logic on aclk.
// Notes: Watchdog overflows leave as one-cycle registered pulses; interval_irq is a registered level.
//
// The AXI4-Lite interface to the registers was decided locally.

module wdt_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_halt,
  input wire logic cpu_stop,
  output logic interval_irq,
  output logic nmi_req,
  output logic system_reset_req
);
  // Bus state
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [wdt_pkg::IDX_W-1:0] aw_idx, next_aw_idx;
  logic [7:0] wbyte, next_wbyte;
  logic wlane, next_wlane;
  logic next_awready, next_wready, next_arready;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  // Timer state
  wdt_pkg::wdt_ctrl_t ctrl, next_ctrl;
  logic [wdt_pkg::CNT_W-1:0] cnt, next_cnt;
  logic irq_flag, next_irq_flag, irq_mask, next_irq_mask;
  logic next_interval_irq, next_nmi_req, next_system_reset_req;
  logic tick, count_en, ovf, do_write, restart_wr, wd_set_evt;
  logic [wdt_pkg::IDX_W-1:0] ar_idx;

  // Halt keeps counting; only the stop state freezes the divider.
  wdt_prescaler #(
    .W(wdt_pkg::PRESC_W)
  ) u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(!cpu_stop),
    .sel(ctrl.clk_sel),
    .tick(tick)
  );

  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign ar_idx = s_axi_araddr[wdt_pkg::ADDR_W-1:2];

  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_idx = aw_idx;
    next_wbyte = wbyte;
    next_wlane = wlane;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_idx = s_axi_awaddr[wdt_pkg::ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_wbyte = s_axi_wdata[7:0];
      next_wlane = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      if (aw_idx == wdt_pkg::IDX_CLOCK_SELECT
          || aw_idx == wdt_pkg::IDX_MODE_CONTROL
          || aw_idx == wdt_pkg::IDX_IRQ_FLAG_REG0) begin
        next_bresp = wdt_pkg::RESP_OKAY;
      end else begin
        next_bresp = wdt_pkg::RESP_SLVERR;
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = wdt_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      unique case (ar_idx)
        wdt_pkg::IDX_CLOCK_SELECT: begin
          next_rdata[wdt_pkg::CSEL_LSB +: wdt_pkg::CSEL_W] = ctrl.clk_sel;
        end
        wdt_pkg::IDX_MODE_CONTROL: begin
          next_rdata[wdt_pkg::RUN_BIT] = ctrl.run;
          next_rdata[wdt_pkg::WD_SEL_BIT] = ctrl.wd_sel;
          next_rdata[wdt_pkg::OVF_ACT_BIT] = ctrl.ovf_act;
        end
        wdt_pkg::IDX_IRQ_FLAG_REG0: begin
          next_rdata[wdt_pkg::IRQ_FLAG_BIT] = irq_flag;
          next_rdata[wdt_pkg::IRQ_MASK_BIT] = irq_mask;
        end
        default: begin
          next_rresp = wdt_pkg::RESP_SLVERR;
        end
      endcase
    end
    // One write and one read at a time; ready drops while a job is held.
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_idx <= '0;
      wbyte <= 8'h00;
      wlane <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_idx <= next_aw_idx;
      wbyte <= next_wbyte;
      wlane <= next_wlane;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  assign restart_wr = do_write && wlane
    && aw_idx == wdt_pkg::IDX_MODE_CONTROL && wbyte[wdt_pkg::RUN_BIT];
  assign wd_set_evt = do_write && wlane
    && aw_idx == wdt_pkg::IDX_MODE_CONTROL && wbyte[wdt_pkg::WD_SEL_BIT];
  // Mode 00 holds the counter even with the restart bit set.
  assign count_en = ctrl.run && (ctrl.wd_sel || ctrl.ovf_act) && tick
    && !restart_wr;
  assign ovf = count_en && cnt == wdt_pkg::CNT_MAX;

  always_comb begin
    next_ctrl = ctrl;
    next_cnt = cnt;
    next_irq_flag = irq_flag;
    next_irq_mask = irq_mask;
    next_nmi_req = 1'b0;
    next_system_reset_req = 1'b0;
    if (do_write && wlane) begin
      if (aw_idx == wdt_pkg::IDX_CLOCK_SELECT) begin
        next_ctrl.clk_sel = wbyte[wdt_pkg::CSEL_LSB +: wdt_pkg::CSEL_W];
      end
      if (aw_idx == wdt_pkg::IDX_MODE_CONTROL) begin
        // Set-only bits: a 0 written leaves them alone.
        next_ctrl.run = ctrl.run | wbyte[wdt_pkg::RUN_BIT];
        next_ctrl.wd_sel = ctrl.wd_sel | wbyte[wdt_pkg::WD_SEL_BIT];
        next_ctrl.ovf_act = ctrl.ovf_act | wbyte[wdt_pkg::OVF_ACT_BIT];
      end
      if (aw_idx == wdt_pkg::IDX_IRQ_FLAG_REG0) begin
        next_irq_flag = wbyte[wdt_pkg::IRQ_FLAG_BIT];
        next_irq_mask = wbyte[wdt_pkg::IRQ_MASK_BIT];
      end
    end
    if (restart_wr) begin
      next_cnt = '0;
    end else if (count_en) begin
      next_cnt = wdt_pkg::CNT_W'(cnt + 1'b1);
    end
    if (ovf) begin
      unique case ({ctrl.wd_sel, ctrl.ovf_act})
        2'h1: next_irq_flag = 1'b1;
        2'h2: next_nmi_req = 1'b1;
        2'h3: next_system_reset_req = 1'b1;
        default: next_irq_flag = irq_flag;
      endcase
    end
    // A pending request turns into a non-maskable irq on selection.
    if (wd_set_evt && irq_flag) begin
      next_nmi_req = 1'b1;
    end
  end

  // Nothing else competes at this level, so the unmasked flag goes out, in interval mode (01) only.
  assign next_interval_irq = irq_flag && !irq_mask
    && !ctrl.wd_sel && ctrl.ovf_act;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= wdt_pkg::CTRL_RESET;
      cnt <= '0;
      irq_flag <= 1'b0;
      irq_mask <= wdt_pkg::IRQ_MASK_RESET;
      interval_irq <= 1'b0;
      nmi_req <= 1'b0;
      system_reset_req <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      cnt <= next_cnt;
      irq_flag <= next_irq_flag;
      irq_mask <= next_irq_mask;
      interval_irq <= next_interval_irq;
      nmi_req <= next_nmi_req;
      system_reset_req <= next_system_reset_req;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_clears_ctrl: assert property (disable iff (1'b0)
    !aresetn |=> ctrl == wdt_pkg::CTRL_RESET && cnt == '0)
    else $error("control not cleared by reset");
  chk_run_sticky: assert property (ctrl.run |=> ctrl.run)
    else $error("restart bit cleared without reset");
  chk_mode_lock: assert property ($rose(ctrl.wd_sel) ##1 1'b1
    |-> ctrl.wd_sel [*4])
    else $error("watchdog select bit cleared");
  chk_idle_no_count: assert property (!ctrl.run |=> cnt == '0)
    else $error("counter moved before restart");
  chk_restart_clear: assert property (restart_wr |=> cnt == '0)
    else $error("restart did not clear counter");
  chk_stop_freeze: assert property (cpu_stop && !restart_wr
    |=> $stable(cnt))
    else $error("counter moved in stop state");
  chk_wrap_count: assert property (ovf |=> cnt == '0)
    else $error("counter did not wrap after 128 ticks");
  chk_interval_flag: assert property (ovf && !ctrl.wd_sel
    |=> irq_flag && !nmi_req && !system_reset_req)
    else $error("interval overflow lost");
  chk_wdt_nmi: assert property (ovf && ctrl.wd_sel && !ctrl.ovf_act
    |=> nmi_req && !system_reset_req)
    else $error("watchdog mode 1 overflow gave no nmi");
  chk_wdt_reset: assert property (ovf && ctrl.wd_sel && ctrl.ovf_act
    |=> system_reset_req && !irq_flag == !$past(irq_flag))
    else $error("watchdog mode 2 overflow gave no reset");
  chk_select_nmi: assert property (wd_set_evt && irq_flag |=> nmi_req)
    else $error("pending flag at selection gave no nmi");
  chk_irq_masked: assert property (interval_irq
    |-> $past(irq_flag) && !$past(irq_mask))
    else $error("interval irq passed its mask");
  chk_irq_mode_gate: assert property (interval_irq
    |-> !$past(ctrl.wd_sel) && $past(ctrl.ovf_act))
    else $error("interval irq outside interval mode");
  chk_reset_req_mode: assert property (system_reset_req
    |-> $past(ctrl.wd_sel) && $past(ctrl.ovf_act))
    else $error("reset request outside watchdog mode 2");
  chk_nmi_in_watchdog: assert property (nmi_req |-> ctrl.wd_sel)
    else $error("nmi request outside watchdog modes");
  chk_mask_blocks: assert property (irq_mask |=> !interval_irq)
    else $error("masked flag reached the interval irq");
  chk_rdata_unused: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("unused read data bits not zero");
endmodule

/* File: tb_wdt_timer.sv */
// Purpose: Self-checking bench for the watchdog/interval timer.
// Assumes: AXI4-Lite register access, byte address = 4 * index.
// Notes: Divide-by-16 and divide-by-64 periods only, so the whole run stays short.
module tb_wdt_timer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] CS = wdt_pkg::IDX_CLOCK_SELECT;
  localparam logic [15:0] MC = wdt_pkg::IDX_MODE_CONTROL;
  localparam logic [15:0] IR = wdt_pkg::IDX_IRQ_FLAG_REG0;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, hit;
  logic [wdt_pkg::ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic cpu_halt, cpu_stop, interval_irq, nmi_req, system_reset_req;
  int error_cnt, n_checks, cyc, n, t1;
  int nmi_cnt, rst_cnt;

  wdt_timer wdt_timer_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cpu_halt(cpu_halt), .cpu_stop(cpu_stop),
    .interval_irq(interval_irq), .nmi_req(nmi_req),
    .system_reset_req(system_reset_req)
  );

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task summarize;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Ceiling sized well above the roughly 34k cycles the scenarios need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end

  // One-cycle pulses may fall while a bus task is busy, so count them here
  always @(posedge aclk) begin
    if (nmi_req === 1'b1) nmi_cnt <= nmi_cnt + 1;
    if (system_reset_req === 1'b1) rst_cnt <= rst_cnt + 1;
  end

  task automatic check(input logic [31:0] got, exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Each channel is released at the edge that takes it; bready held to bvalid
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 60);
    rsp = bresp;
    if (bvalid !== 1'b1) check(32'h0, 32'h1, "write hang");
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdr(input logic [15:0] idx);
    int k;
    k = 0;
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 60);
    rd = rdata;
    rsp = rresp;
    if (rvalid !== 1'b1) check(32'h0, 32'h1, "read hang");
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  function automatic logic pick(input int s);
    return (s == 0) ? interval_irq : (s == 1) ? nmi_req : system_reset_req;
  endfunction

  // Leaves the cycles waited in n and whether the output was seen in hit
  task automatic wait_hi(input int s, input int mx);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (pick(s) !== 1'b1 && n < mx);
    hit = pick(s);
  endtask

  task automatic t_reset_vals;
    rdr(CS);
    check(rd, 32'h0, "clock select reset");
    rdr(MC);
    check(rd, 32'h0, "mode reset");
    rdr(IR);
    check(rd, 32'h2, "irq reg reset");
    rdr(16'h0123);
    check(32'(rsp), 32'(wdt_pkg::RESP_SLVERR), "unmapped read");
  endtask

  task automatic t_fields;
    wr(CS, 8'hff);
    rdr(CS);
    check(rd, 32'h7, "clock select field");
    wr(CS, 8'h00);
    wr(MC, 8'h08);
    wr(MC, 8'h67);
    rdr(MC);
    check(rd, 32'h8, "mode lock and unused");
    wr(16'h0321, 8'h55);
    check(32'(rsp), 32'(wdt_pkg::RESP_SLVERR), "unmapped write");
    wr(IR, 8'h00);
    wait_hi(0, 2200);
    check(32'(hit), 32'h0, "counting without run");
  endtask

  task automatic t_interval;
    wr(MC, 8'h88);
    wait_hi(0, 2100);
    check(32'(hit), 32'h1, "first interval");
    check(32'(n >= 2010 && n <= 2056), 32'h1, "first period");
    t1 = cyc;
    wr(IR, 8'h00);
    wait_hi(0, 2100);
    check(32'(cyc - t1), 32'd2048, "interval period");
    cpu_halt <= 1'b1;
    wr(IR, 8'h02);
    wait_hi(0, 2100);
    check(32'(hit), 32'h0, "masked interval");
    rdr(IR);
    check(rd, 32'h3, "flag set in halt");
    cpu_halt <= 1'b0;
    wr(IR, 8'h02);
    wr(MC, 8'h88);
    cpu_stop <= 1'b1;
    repeat (2200) @(posedge aclk);
    rdr(IR);
    check(rd, 32'h2, "frozen in stop");
    cpu_stop <= 1'b0;
  endtask

  task automatic t_watchdog;
    wr(IR, 8'h01);
    t1 = nmi_cnt;
    wr(MC, 8'h90);
    check(32'(nmi_cnt - t1), 32'h1, "nmi on watchdog select");
    check(32'(interval_irq), 32'h0, "no irq in mode 11");
    rdr(MC);
    check(rd, 32'h98, "run and mode locked");
    for (int i = 0; i < 3; i++) begin
      wait_hi(2, 1500);
      check(32'(hit), 32'h0, "restarted watchdog");
      wr(MC, 8'h80);
    end
    check(32'(rst_cnt), 32'h0, "reset while restarted");
    wait_hi(2, 2100);
    check(32'(hit), 32'h1, "watchdog reset");
  endtask

  task automatic t_nmi_period;
    do_reset();
    rdr(MC);
    check(rd, 32'h0, "mode cleared by reset");
    rdr(IR);
    check(rd, 32'h2, "flag clear before select");
    wr(CS, 8'h02);
    wr(MC, 8'h90);
    wait_hi(1, 8300);
    check(32'(hit), 32'h1, "watchdog nmi");
    wait_hi(1, 8300);
    check(32'(n), 32'd8192, "nmi period div 64");
  endtask

  initial begin
    error_cnt = 0;
    n_checks = 0;
    cyc = 0;
    nmi_cnt = 0;
    rst_cnt = 0;
    aresetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    cpu_halt = 1'b0;
    cpu_stop = 1'b0;
    do_reset();
    t_reset_vals();
    t_fields();
    t_interval();
    t_watchdog();
    t_nmi_period();
    summarize();
  end
endmodule
